/* File: common/dfi_pkg.sv */
package dfi_pkg;
   // bank organisation
   localparam int BG_W          = 2;
   localparam int BA_W          = 2;
   localparam int ROW_W         = 18;
   localparam int COL_W         = 10;
   localparam int ADDR_W        = 18;
   localparam int BG_X16_MASK_W = 1;
   // command field encodings on the link (act_n,ras,cas,we)
   localparam logic [3:0] CMD_ACT   = 4'h0;
   localparam logic [3:0] CMD_MRS   = 4'h8;
   localparam logic [3:0] CMD_REF   = 4'h9;
   localparam logic [3:0] CMD_PRE   = 4'hA;
   localparam logic [3:0] CMD_WR    = 4'hC;
   localparam logic [3:0] CMD_RD    = 4'hD;
   localparam logic [3:0] CMD_ZQCL  = 4'hE;
   localparam logic [3:0] CMD_NOP   = 4'hF;
   // column command address bits
   localparam int AP_BIT  = 10;
   localparam int BC_BIT  = 12;
   // mode register field positions and defaults
   localparam int MR3_GEARDOWN_BIT = 3;
   localparam int MR3_PDA_BIT      = 4;
   localparam int MR4_MPS_BIT      = 1;
   localparam int MR4_CAL_LO       = 6;
   localparam int MR4_CAL_HI       = 8;
   localparam int MR4_SPPR_BIT     = 5;
   localparam int MR4_HPPR_BIT     = 13;
   localparam int MR5_PL_LO        = 0;
   localparam int MR5_PL_HI        = 2;
   localparam int MR0_BL_LO        = 0;
   localparam int MR0_BL_HI        = 1;
   localparam int MR5_WCRC_BIT     = 12;
   localparam logic [17:0] MR_RESET_VALUE = 18'h00000;
   localparam logic [1:0]  BL_FIXED8 = 2'h0;
   localparam logic [1:0]  BL_OTF    = 2'h1;
   localparam logic [1:0]  BL_FIXED4 = 2'h2;
   localparam int BURST8_BEATS = 8;
   localparam int BURST4_BEATS = 4;
   localparam int BEAT_W       = 4;
   // timing, figures as printed
   localparam int PCLK_MHZ        = 200;
   localparam int CKE_SETUP_NS    = 10;
   localparam int TEN_LOW_US      = 700;
   localparam int RESET_EXIT_US   = 500;
   localparam int CLK_STABLE_TCK  = 5;
   localparam int TXPR_TCK        = 5;
   localparam int LINK_DIV        = 4;   // pclk cycles per link half period
   localparam int CKE_SETUP_CYC   = (CKE_SETUP_NS * PCLK_MHZ + 999) / 1000;
   localparam int TEN_LOW_CYC     = TEN_LOW_US * PCLK_MHZ;
   localparam int RESET_EXIT_CYC  = RESET_EXIT_US * PCLK_MHZ;
   localparam int TMRD_TCK        = 8;
   localparam int CNT_W           = 20;
   // controller register map (APB byte offsets)
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_CMD    = 8'h08;
   localparam logic [7:0] REG_ADDR   = 8'h0C;
   localparam logic [7:0] REG_MRVAL  = 8'h10;
   localparam int CTRL_START_BIT = 0;
   localparam int CMD_GO_BIT     = 31;
   // init states, gray along the usual path
   typedef enum logic [2:0] {
      DFI_RST   = 3'b000,
      DFI_WAIT  = 3'b001,
      DFI_CLKON = 3'b011,
      DFI_XPR   = 3'b010,
      DFI_MRS   = 3'b110,
      DFI_ZQ    = 3'b111,
      DFI_READY = 3'b101
   } dfi_state_type;
endpackage : dfi_pkg

/* File: common/dfi_if.sv */
`timescale 1ns/1ps
interface dfi_if;
   logic        ck;
   logic        cke;
   logic        reset_n;
   logic        boundary_scan_enable_pin;
   logic        cs_n;
   logic [3:0]  cmd;
   logic [1:0]  bg;
   logic [1:0]  ba;
   logic [17:0] addr;
   logic        dq_strobe;      // device burst beat strobe
   logic        init_done;      // device has completed initialisation
   modport ctrl (
      output ck, cke, reset_n, boundary_scan_enable_pin, cs_n, cmd, bg, ba,
             addr,
      input  dq_strobe, init_done
   );
   modport mem (
      input  ck, cke, reset_n, boundary_scan_enable_pin, cs_n, cmd, bg, ba,
             addr,
      output dq_strobe, init_done
   );
endinterface : dfi_if

/* File: hw/dfi_mem.sv */
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
// Summary of operation
// - x8 sixteen banks, x16 eight banks
// - eight-word prefetch, two words per clock
// - bursts of eight or chopped four beats
// - activate latches bank group, bank, row
// - column, auto-precharge, on-the-fly chop from address
// - no-operation only for power-saving exit, gear-down
// - gear-down and per-device addressing default zero
// - power-saving and cs latency default zero
// - parity latency and repair bits default zero
// - reset and scan enable held low
// - clock enable low before reset release
// - reset released within ten minutes
// - initialisation begins within three seconds
// - debug mode stretches limits to sixty minutes
// - writes fixed eight, four, or on-the-fly
// - wait 500 us before clock enable
// - stable clock before clock enable
// - wait reset-exit time before first mode write
// - load mode registers 3,6,5,4,2,1,0, then calibrate
module dfi_mem #(
   parameter bit X16 = 1'b0
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   dfi_if.mem                     lnk,
   output logic [dfi_pkg::BG_W-1:0]  open_bg,
   output logic [dfi_pkg::BA_W-1:0]  open_ba,
   output logic [dfi_pkg::ROW_W-1:0] open_row,
   output logic [dfi_pkg::COL_W-1:0] burst_col,
   output logic                      burst_write,
   output logic                      burst_ap,
   output logic                      burst_active,
   output logic                      nop_violation
);
   import dfi_pkg::*;

   // link pins other than scan enable cross into pclk through two flops each
   logic [29:0] sync1_reg, sync2_reg, sync_next;
   logic        ck_prev_reg;
   always_comb begin
      sync_next = {lnk.ck, lnk.cke, lnk.reset_n, lnk.cs_n, lnk.cmd,
                   lnk.bg, lnk.ba, lnk.addr};
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg   <= 30'h00000000;
         sync2_reg   <= 30'h00000000;
         ck_prev_reg <= 1'b0;
      end else begin
         sync1_reg   <= sync_next;
         sync2_reg   <= sync1_reg;
         ck_prev_reg <= sync2_reg[29];
      end
   end
   wire        s_cke   = sync2_reg[28];
   wire        s_rstn  = sync2_reg[27];
   wire        s_csn   = sync2_reg[26];
   wire [3:0]  s_cmd   = sync2_reg[25:22];
   wire [1:0]  s_bg    = sync2_reg[21:20];
   wire [1:0]  s_ba    = sync2_reg[19:18];
   wire [17:0] s_addr  = sync2_reg[17:0];
   wire        ck_rise = sync2_reg[29] & ~ck_prev_reg;
   wire        cmd_ok  = ck_rise & s_cke & ~s_csn;

   // mode registers, burst tracker and init progress
   logic [17:0] mr_reg [0:6];
   logic [17:0] mr_next [0:6];
   logic [2:0]  mrs_idx_reg, mrs_idx_next;
   logic        done_reg, done_next;
   logic [BG_W-1:0]  bg_reg, bg_next;
   logic [BA_W-1:0]  ba_reg, ba_next;
   logic [ROW_W-1:0] row_reg, row_next;
   logic [COL_W-1:0] col_reg, col_next;
   logic        wr_reg, wr_next, ap_reg, ap_next;
   logic [BEAT_W-1:0] beats_reg, beats_next;
   logic        strobe_reg, strobe_next;
   logic        nop_reg, nop_next;
   logic [2:0]  seq_mr;
   logic [1:0]  bl_mode;
   logic        chop;

   // expected mode register for each step of the load order
   always_comb begin
      unique case (mrs_idx_reg)
         3'h0: seq_mr = 3'h3;
         3'h1: seq_mr = 3'h6;
         3'h2: seq_mr = 3'h5;
         3'h3: seq_mr = 3'h4;
         3'h4: seq_mr = 3'h2;
         3'h5: seq_mr = 3'h1;
         default: seq_mr = 3'h0;
      endcase
   end

   always_comb begin
      for (int i = 0; i < 7; i++) mr_next[i] = mr_reg[i];
      mrs_idx_next = mrs_idx_reg;
      done_next    = done_reg;
      bg_next      = bg_reg;
      ba_next      = ba_reg;
      row_next     = row_reg;
      col_next     = col_reg;
      wr_next      = wr_reg;
      ap_next      = ap_reg;
      beats_next   = beats_reg;
      strobe_next  = 1'b0;
      nop_next     = nop_reg;
      bl_mode      = mr_reg[0][MR0_BL_HI:MR0_BL_LO];
      chop         = (bl_mode == BL_FIXED4) ||
                     ((bl_mode == BL_OTF) && !s_addr[BC_BIT]);
      // two beats per link clock, eight per prefetch
      if (beats_reg != 4'h0 && ck_rise) begin
         beats_next  = (beats_reg > 4'h2) ? beats_reg - 4'h2 : 4'h0;
         strobe_next = 1'b1;
      end
      if (!s_rstn) begin
         // reset forces defaults and ignores commands
         for (int i = 0; i < 7; i++) mr_next[i] = MR_RESET_VALUE;
         mrs_idx_next = 3'h0;
         done_next    = 1'b0;
         beats_next   = 4'h0;
      end else if (cmd_ok) begin
         unique case (s_cmd)
            CMD_MRS: begin
               // out-of-order mode writes ignored in init
               // index 7 has no register; a finished load order stops
               if (({s_bg[0], s_ba} != 3'h7) &&
                   (done_reg || ((mrs_idx_reg != 3'h7) &&
                                 ({s_bg[0], s_ba} == seq_mr)))) begin
                  mr_next[{s_bg[0], s_ba}] = s_addr;
                  if (!done_reg) mrs_idx_next = mrs_idx_reg + 3'h1;
               end
            end
            CMD_ZQCL: begin
               if (mrs_idx_reg == 3'h7) done_next = 1'b1;
            end
            CMD_ACT: begin
               if (done_reg) begin
                  bg_next  = X16 ? {1'b0, s_bg[0]} : s_bg;
                  ba_next  = s_ba;
                  row_next = s_addr;
               end
            end
            CMD_RD, CMD_WR: begin
               if (done_reg) begin
                  col_next   = s_addr[COL_W-1:0];
                  ap_next    = s_addr[AP_BIT];
                  wr_next    = (s_cmd == CMD_WR);
                  beats_next = chop ? 4'(BURST4_BEATS) : 4'(BURST8_BEATS);
               end
            end
            CMD_NOP: begin
               // flag a no-operation outside its two uses
               if (!mr_reg[4][MR4_MPS_BIT] && !mr_reg[3][MR3_GEARDOWN_BIT])
                  nop_next = 1'b1;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 7; i++) mr_reg[i] <= 18'h00000;
         mrs_idx_reg <= 3'h0;
         done_reg    <= 1'b0;
         bg_reg      <= 2'h0;
         ba_reg      <= 2'h0;
         row_reg     <= 18'h00000;
         col_reg     <= 10'h000;
         wr_reg      <= 1'b0;
         ap_reg      <= 1'b0;
         beats_reg   <= 4'h0;
         strobe_reg  <= 1'b0;
         nop_reg     <= 1'b0;
      end else begin
         for (int i = 0; i < 7; i++) mr_reg[i] <= mr_next[i];
         mrs_idx_reg <= mrs_idx_next;
         done_reg    <= done_next;
         bg_reg      <= bg_next;
         ba_reg      <= ba_next;
         row_reg     <= row_next;
         col_reg     <= col_next;
         wr_reg      <= wr_next;
         ap_reg      <= ap_next;
         beats_reg   <= beats_next;
         strobe_reg  <= strobe_next;
         nop_reg     <= nop_next;
      end
   end

   // outputs straight from flops
   logic act_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) act_reg <= 1'b0;
      else act_reg <= (beats_reg != 4'h0);
   end
   assign open_bg       = bg_reg;
   assign open_ba       = ba_reg;
   assign open_row      = row_reg;
   assign burst_col     = col_reg;
   assign burst_write   = wr_reg;
   assign burst_ap      = ap_reg;
   assign burst_active  = act_reg;
   assign nop_violation = nop_reg;
   assign lnk.dq_strobe = strobe_reg;
   assign lnk.init_done = done_reg;
endmodule : dfi_mem

/* File: hw/dfi_ctrl.sv */
`timescale 1ns/1ps
module dfi_ctrl #(
   parameter int TEN_LOW_CYCLES   = dfi_pkg::TEN_LOW_CYC,
   parameter int RESET_EXIT_CYCLES = dfi_pkg::RESET_EXIT_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   dfi_if.ctrl              lnk
);
   import dfi_pkg::*;

   dfi_state_type st_reg, st_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [2:0]  div_reg, div_next;
   logic        ck_reg, ck_next, cke_reg, cke_next, rstn_reg, rstn_next;
   logic        ten_reg, ten_next, csn_reg, csn_next;
   logic [3:0]  cmd_reg, cmd_next;
   logic [1:0]  bg_reg, bg_next, ba_reg, ba_next;
   logic [17:0] addr_reg, addr_next;
   logic [2:0]  mrs_reg, mrs_next;
   logic [17:0] mrval_reg, mrval_next, uaddr_reg, uaddr_next;
   logic [31:0] ucmd_reg, ucmd_next;
   logic        start_reg, start_next;
   logic [31:0] rd_reg, rd_next;
   logic [1:0]  done_sync_reg;
   logic [2:0]  mr_id;
   wire         fall = (div_reg == 3'(LINK_DIV - 1)) && ck_reg;
   wire         acc  = psel && penable;

   // mode register load order
   always_comb begin
      unique case (mrs_reg)
         3'h0: mr_id = 3'h3;
         3'h1: mr_id = 3'h6;
         3'h2: mr_id = 3'h5;
         3'h3: mr_id = 3'h4;
         3'h4: mr_id = 3'h2;
         3'h5: mr_id = 3'h1;
         default: mr_id = 3'h0;
      endcase
   end

   // apb registers, init sequencer and link clock divider
   always_comb begin
      st_next = st_reg; cnt_next = cnt_reg; mrs_next = mrs_reg;
      div_next = (div_reg == 3'(LINK_DIV - 1)) ? 3'h0 : div_reg + 3'h1;
      ck_next  = (div_reg == 3'(LINK_DIV - 1)) ? ~ck_reg : ck_reg;
      cke_next = cke_reg; rstn_next = rstn_reg; ten_next = ten_reg;
      csn_next = csn_reg; cmd_next = cmd_reg; bg_next = bg_reg;
      ba_next = ba_reg; addr_next = addr_reg;
      start_next = start_reg; mrval_next = mrval_reg;
      uaddr_next = uaddr_reg; ucmd_next = ucmd_reg; rd_next = 32'h00000000;
      if (acc && pwrite) begin
         unique case (paddr)
            REG_CTRL:  start_next = pwdata[CTRL_START_BIT];
            REG_CMD:   ucmd_next  = pwdata;
            REG_ADDR:  uaddr_next = pwdata[17:0];
            REG_MRVAL: mrval_next = pwdata[17:0];
            default: ;
         endcase
      end
      unique case (paddr)
         REG_CTRL:   rd_next = {31'h00000000, start_reg};
         REG_CMD:    rd_next = ucmd_reg;
         REG_STATUS: rd_next = {25'h0000000, done_sync_reg[1], cke_reg,
                                rstn_reg, 1'b0, st_reg};
         REG_ADDR:   rd_next = {14'h0000, uaddr_reg};
         REG_MRVAL:  rd_next = {14'h0000, mrval_reg};
         default:    rd_next = 32'h00000000;
      endcase
      // commands change on falling link edge, seen at the rising one
      if (fall) begin
         csn_next = 1'b1;
         cmd_next = CMD_REF;
         if (cnt_reg != '0) cnt_next = cnt_reg - 1'b1;
         unique case (st_reg)
            DFI_RST: begin
               // reset and scan enable low, cke low
               rstn_next = 1'b0; ten_next = 1'b0; cke_next = 1'b0;
               if (start_reg) begin
                  st_next = DFI_WAIT;
                  cnt_next = CNT_W'(TEN_LOW_CYCLES / (2 * LINK_DIV) + 1);
               end
            end
            DFI_WAIT: begin
               // release reset once low time is met
               if (cnt_reg == '0) begin
                  rstn_next = 1'b1;
                  st_next = DFI_CLKON;
                  cnt_next = CNT_W'(RESET_EXIT_CYCLES / (2 * LINK_DIV) + 1);
               end
            end
            DFI_CLKON: begin
               // cke after 500 us of running clock
               if (cnt_reg == '0) begin
                  cke_next = 1'b1; st_next = DFI_XPR;
                  cnt_next = CNT_W'(TXPR_TCK);
               end
            end
            DFI_XPR: begin
               // reset exit time before first mode write
               if (cnt_reg == '0) st_next = DFI_MRS;
            end
            DFI_MRS: begin
               // ordered loads with delay after each
               if (cnt_reg == '0) begin
                  csn_next = 1'b0;
                  if (mrs_reg == 3'h7) begin
                     cmd_next = CMD_ZQCL; st_next = DFI_ZQ;
                  end else begin
                     cmd_next = CMD_MRS;
                     {bg_next[0], ba_next} = mr_id;
                     addr_next = (mr_id == 3'h0) ? mrval_reg : 18'h00000;
                     mrs_next = mrs_reg + 3'h1;
                     cnt_next = CNT_W'(TMRD_TCK);
                  end
               end
            end
            DFI_ZQ: if (done_sync_reg[1]) st_next = DFI_READY;
            DFI_READY: begin
               // user commands, a no-operation is dropped
               if (ucmd_reg[CMD_GO_BIT]) begin
                  ucmd_next[CMD_GO_BIT] = 1'b0;
                  if (ucmd_reg[3:0] != CMD_NOP) begin
                     csn_next = 1'b0; cmd_next = ucmd_reg[3:0];
                     {bg_next, ba_next} = ucmd_reg[7:4];
                     addr_next = uaddr_reg;
                  end
               end
            end
            default: st_next = DFI_RST;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= DFI_RST; cnt_reg <= '0; div_reg <= 3'h0;
         ck_reg <= 1'b0; cke_reg <= 1'b0; rstn_reg <= 1'b0;
         ten_reg <= 1'b0; csn_reg <= 1'b1; cmd_reg <= 4'h9;
         bg_reg <= 2'h0; ba_reg <= 2'h0; addr_reg <= 18'h00000;
         mrs_reg <= 3'h0; mrval_reg <= 18'h00000; uaddr_reg <= 18'h00000;
         ucmd_reg <= 32'h00000000; start_reg <= 1'b0;
         rd_reg <= 32'h00000000; done_sync_reg <= 2'h0;
      end else begin
         st_reg <= st_next; cnt_reg <= cnt_next; div_reg <= div_next;
         ck_reg <= ck_next; cke_reg <= cke_next; rstn_reg <= rstn_next;
         ten_reg <= ten_next; csn_reg <= csn_next; cmd_reg <= cmd_next;
         bg_reg <= bg_next; ba_reg <= ba_next; addr_reg <= addr_next;
         mrs_reg <= mrs_next; mrval_reg <= mrval_next;
         uaddr_reg <= uaddr_next; ucmd_reg <= ucmd_next;
         start_reg <= start_next; rd_reg <= rd_next;
         done_sync_reg <= {done_sync_reg[0], lnk.init_done};
      end
   end

   // apb answers in the access cycle, zero wait states
   assign prdata  = rd_reg;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign lnk.ck = ck_reg;
   assign lnk.cke = cke_reg;
   assign lnk.reset_n = rstn_reg;
   assign lnk.boundary_scan_enable_pin = ten_reg;
   assign lnk.cs_n = csn_reg;
   assign lnk.cmd = cmd_reg;
   assign lnk.bg = bg_reg;
   assign lnk.ba = ba_reg;
   assign lnk.addr = addr_reg;
endmodule : dfi_ctrl

/* File: verification/dfi_chk.sv */
`timescale 1ns/1ps
module dfi_chk
   import dfi_pkg::*;
#(
   parameter int RESET_EXIT_CYCLES = RESET_EXIT_CYC
) (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       cke,
   input wire logic       reset_n,
   input wire logic       cs_n,
   input wire logic [3:0] cmd,
   input wire logic       dq_strobe,
   input wire logic       init_done
);
   // reset-exit wait expressed in pclk cycles of the link
   localparam int XPR_CYC = TXPR_TCK * 2 * LINK_DIV;
   logic [15:0] rx_cnt_reg;
   logic [15:0] rx_cnt_next;
   logic [7:0]  up_cnt_reg;
   logic [7:0]  up_cnt_next;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // cycles since reset_n and cke went high; saturate so no wrap
   always_comb begin
      rx_cnt_next = reset_n ? rx_cnt_reg + 16'(rx_cnt_reg != 16'hFFFF) : '0;
      up_cnt_next = cke ? up_cnt_reg + 8'(up_cnt_reg != 8'hFF) : '0;
   end
   // counter registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_cnt_reg <= '0;
         up_cnt_reg <= '0;
      end else begin
         rx_cnt_reg <= rx_cnt_next;
         up_cnt_reg <= up_cnt_next;
      end
   end
   property p_no_nop;
      cmd != CMD_NOP;
   endproperty
   a_no_nop: assert property (p_no_nop)
      else $error("host drove a no-operation");
   property p_cke_rel;
      $rose(reset_n) |-> !cke && !$past(cke, 2);
   endproperty
   a_cke_rel: assert property (p_cke_rel)
      else $error("cke not low before reset release");
   property p_rx_wait;
      $rose(cke) |-> reset_n && rx_cnt_reg >= RESET_EXIT_CYCLES;
   endproperty
   a_rx_wait: assert property (p_rx_wait)
      else $error("cke raised too early after reset");
   property p_xpr;
      !cs_n && cmd == CMD_MRS |-> cke && up_cnt_reg >= XPR_CYC;
   endproperty
   a_xpr: assert property (p_xpr)
      else $error("mode write before reset-exit time");
   property p_init_up;
      $rose(init_done) |-> cke && reset_n;
   endproperty
   a_init_up: assert property (p_init_up)
      else $error("ready without cke and reset high");
   property p_rst_init;
      !reset_n [*4] |-> !init_done;
   endproperty
   a_rst_init: assert property (p_rst_init)
      else $error("ready while link reset held");
   property p_no_early;
      !init_done |-> !dq_strobe;
   endproperty
   a_no_early: assert property (p_no_early)
      else $error("burst beat before ready");
   property p_beat_gap;
      dq_strobe |=> !dq_strobe [*7];
   endproperty
   a_beat_gap: assert property (p_beat_gap)
      else $error("beat strobes closer than a link period");
endmodule : dfi_chk

/* File: verification/dfi_tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin \
   num_errors++; $display("wrong value %s exp %0h got %0h", nm, ex, gt); \
   end end
module dfi_tb_top;
   import dfi_pkg::*;
   localparam int SIM_CYC = 64;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] rd_data;
   logic [1:0]  m_bg;
   logic [1:0]  m_ba;
   logic [17:0] m_row;
   logic [9:0]  m_col;
   logic        m_wr;
   logic        m_ap;
   logic        m_busy;
   logic        m_nop;
   logic [17:0] b_row;
   logic        b_nop;
   int          num_errors;
   int          num_checks;
   int          n_strb = 0;
   int          s0;
   dfi_if dl();
   dfi_if bl();
   dfi_ctrl #(.TEN_LOW_CYCLES(SIM_CYC), .RESET_EXIT_CYCLES(SIM_CYC))
      dfi_ctrl_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .lnk(dl));
   dfi_mem #(.X16(1'b0)) dfi_mem_i (
      .pclk(pclk), .presetn(presetn), .lnk(dl), .open_bg(m_bg),
      .open_ba(m_ba), .open_row(m_row), .burst_col(m_col),
      .burst_write(m_wr), .burst_ap(m_ap), .burst_active(m_busy),
      .nop_violation(m_nop));
   // second device on a link the bench drives, to break host duties
   dfi_mem #(.X16(1'b1)) dfi_mem_x16_i (
      .pclk(pclk), .presetn(presetn), .lnk(bl), .open_bg(), .open_ba(),
      .open_row(b_row), .burst_col(), .burst_write(), .burst_ap(),
      .burst_active(), .nop_violation(b_nop));
   dfi_chk #(.RESET_EXIT_CYCLES(SIM_CYC)) dfi_chk_i (
      .pclk(pclk), .presetn(presetn), .cke(dl.cke), .reset_n(dl.reset_n),
      .cs_n(dl.cs_n), .cmd(dl.cmd), .dq_strobe(dl.dq_strobe),
      .init_done(dl.init_done));
   // 200 MHz bus clock
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // each strobe carries two beats
   always @(posedge pclk) begin
      if (dl.dq_strobe === 1'b1) begin
         n_strb <= n_strb + 1;
      end
   end
   task automatic stop_test();
      if (num_errors == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : stop_test
   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait for pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd_data = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // user command: address, then go; waits until go clears, polling at most 100 reads
   task automatic usr_cmd(input logic [3:0] c, input logic [3:0] gb,
                          input logic [31:0] a);
      int n;
      apb(1'b1, REG_ADDR, a);
      apb(1'b1, REG_CMD, {1'b1, 23'h000000, gb, c});
      rd_data = 32'hFFFFFFFF;
      for (n = 0; n < 100 && rd_data[31] !== 1'b0; n++)
         apb(1'b0, REG_CMD, 32'h00000000);
      repeat (24) @(posedge pclk);
   endtask : usr_cmd
   // link clock periods of 48 ns on the bench link, still otherwise
   task automatic bck(input int n);
      repeat (n) begin
         #24 bl.ck = 1'b1;
         #24 bl.ck = 1'b0;
      end
      @(posedge pclk);
   endtask : bck
   // hang guard
   initial begin
      #300000;
      num_errors++;
      stop_test();
   end
   initial begin
      num_errors = 0;
      num_checks = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      bl.ck = 1'b0;
      bl.cke = 1'b0;
      bl.reset_n = 1'b0;
      bl.boundary_scan_enable_pin = 1'b0;
      bl.cs_n = 1'b1;
      bl.cmd = CMD_REF;
      bl.bg = 2'h0;
      bl.ba = 2'h0;
      bl.addr = 18'h00000;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, REG_STATUS, 32'h00000000);
      `CHK("status", 32'h0, rd_data & 32'h77)
      // commands sent before the device may take them
      bl.cke <= 1'b1;
      bl.cs_n <= 1'b0;
      bl.cmd <= CMD_NOP;
      bck(4);
      `CHK("nop in reset", 1'b0, b_nop)
      bl.reset_n <= 1'b1;
      bl.cmd <= CMD_ACT;
      bl.addr <= 18'h3FFFF;
      bck(4);
      `CHK("early row", 18'h0, b_row)
      bl.cmd <= CMD_NOP;
      bck(4);
      `CHK("nop flag", 1'b1, b_nop)
      bl.cs_n <= 1'b1;
      // power-up with on-the-fly burst length
      apb(1'b1, REG_MRVAL, {30'h0, BL_OTF});
      apb(1'b1, REG_CTRL, 32'h00000001);
      for (int n = 0; n < 20000 && dl.init_done !== 1'b1; n++)
         @(posedge pclk);
      `CHK("ready", 1'b1, dl.init_done)
      // ready state waits for the synchronised flag and a link fall
      repeat (16) @(posedge pclk);
      apb(1'b0, REG_STATUS, 32'h00000000);
      `CHK("status up", {25'h0, 3'h7, 1'b0, DFI_READY}, rd_data & 32'h77)
      usr_cmd(CMD_ACT, 4'h9, 32'h0002A5C3);
      `CHK("bank group", 2'h2, m_bg)
      `CHK("bank", 2'h1, m_ba)
      `CHK("row", 18'h2A5C3, m_row)
      // reads and writes, chopped and full, with and without precharge
      for (int i = 0; i < 4; i++) begin
         s0 = n_strb;
         usr_cmd(i[1] ? CMD_WR : CMD_RD, 4'h9,
                 {19'h0, i[0], 1'b0, i[0] ^ i[1], 10'(240 + i)});
         repeat (200) @(posedge pclk);
         `CHK("beats", i[0] ? 4 : 2, n_strb - s0)
         `CHK("column", 10'(240 + i), m_col)
         `CHK("write", i[1], m_wr)
         `CHK("precharge", i[0] ^ i[1], m_ap)
         `CHK("idle", 1'b0, m_busy)
      end
      // a requested no-operation must be dropped, never sent
      usr_cmd(CMD_NOP, 4'h0, 32'h00000000);
      `CHK("nop dropped", 1'b0, rd_data[31])
      `CHK("no nop", 1'b0, m_nop)
      // mid-run reset, then fixed chop: A12 no longer selects
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      `CHK("reset ready", 1'b0, dl.init_done)
      apb(1'b1, REG_MRVAL, {30'h0, BL_FIXED4});
      apb(1'b1, REG_CTRL, 32'h00000001);
      for (int n = 0; n < 20000 && dl.init_done !== 1'b1; n++)
         @(posedge pclk);
      repeat (16) @(posedge pclk);
      s0 = n_strb;
      usr_cmd(CMD_RD, 4'h9, 32'h000010F0);
      repeat (200) @(posedge pclk);
      `CHK("fixed chop", 2, n_strb - s0)
      `CHK("fixed column", 10'h0F0, m_col)
      stop_test();
   end
endmodule : dfi_tb_top
